// ==== inc/mip_pkg.sv ====
/*
 package for the interrupt, power and reset control block:
 register offsets, reset values, field positions, state type.
 assumes a 32-bit apb with byte addresses.
*/
`default_nettype none
package mip_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_SFC    = 8'h08;
  localparam logic [7:0] OFF_OPMODE = 8'h0c;
  localparam logic [7:0] OFF_LO_A   = 8'h10;
  localparam logic [7:0] OFF_HI_A   = 8'h14;
  localparam logic [7:0] OFF_LO_B   = 8'h18;
  localparam logic [7:0] OFF_HI_B   = 8'h1c;
  localparam logic [7:0] OFF_PCNT   = 8'h20;
  // reset values
  localparam logic [7:0] RST_SFC    = 8'hd7;
  localparam logic [7:0] RST_OPMODE = 8'he0;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_THR    = 8'h00;
  // status / mask bit positions
  localparam int B_TIMER   = 0;
  localparam int B_EP0     = 1;
  localparam int B_SUSPEND = 2;
  localparam int B_USBRST  = 3;
  localparam int B_PORT7   = 4;
  localparam int B_PAT_A   = 5;
  localparam int B_PAT_B   = 6;
  localparam int B_RESUME  = 7;
  // special function control fields
  localparam int SFC_DEV_RESUME = 3;
  localparam int SFC_RUN        = 4;
  localparam int SFC_WDT_EN     = 5;
  localparam int SFC_WAKE_N     = 6;
  localparam int SFC_DUAL_N     = 7;
  // operation mode fields
  localparam int OPM_PAT_EN = 2;
  localparam int OPM_FRQ_LO = 6;
  // interrupt vector and pattern full count
  localparam int          PC_W        = 13;
  localparam logic [12:0] IRQ_VECTOR  = 13'h0001;
  localparam logic [7:0]  PAT_FULL    = 8'hff;
  // pattern sample period
  localparam logic [15:0] PAT_TICK_CYCLES = 16'h0010;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [7:0]  sfc;
    logic [7:0]  opmode;
    logic [7:0]  lo_a;
    logic [7:0]  hi_a;
    logic [7:0]  lo_b;
    logic [7:0]  hi_b;
    logic        gie;
    logic        usb_live;
    logic        susp_prev;
    logic [7:0]  p7_s1;
    logic [7:0]  p7_s2;
    logic [7:0]  p7_prev;
    logic [1:0]  pat_s1;
    logic [1:0]  pat_s2;
    logic [1:0]  pat_prev;
    logic [7:0]  cnt_a;
    logic [7:0]  cnt_b;
    logic [15:0] tick;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        take;
    logic        restart;
  } mip_state_t;
endpackage
`default_nettype wire

// ==== hdl/mip_ctrl.sv ====
/*
 interrupt, power-saving and reset control for a small usb mcu.
 assumes: core, timer, watchdog and usb controller logic share
 clock_in; port 7 and pattern pins come from pads.
*/
// What this block does
// (R1) all sources share one vector, program address 0x0001
// (R2) timer counter overflow sets status bit 0
// (R3) any port 7 input change sets status bit 4
// (R4) pattern channel one edge or full count sets status bit 5
// (R5) pattern channel two, own thresholds, sets status bit 6
// (R6) accepted endpoint zero setup with unsupported command sets status bit 1
// (R7) usb suspend signalling sets status bit 2
// (R8) usb reset signalling sets status bit 3; requests interrupt only with mask bit 3 set
// (R9) leaving suspend without own resume drive sets status bit 7, only with dual clock bit low and run bit set
// (R10) a masked source never vectors
// (R11) status bits set whether masked or not
// (R12) firmware clears serviced status bits; no automatic clear
// (R13) enable and return instructions set global enable, disable clears
// (R14) clearing run bit stops oscillator and sleeps
// (R15) wake on host resume, watchdog reset or enabled port change
// (R16) firmware sets port to input and reads it before sleeping
// (R17) dual clock bit low selects slow internal oscillator
// (R18) host resume interrupt only in dual clock mode, sleep wakes
// (R19) watchdog overflow restarts program, usb state kept
// (R20) power-on reset clears state and loads initial register values
// (R21) usb events ignored after attach until bus reset seen
// (R22) only unsupported commands interrupt the core
// (R23) mask bits 0..7 enable sources in status bit order
// (R24) frequency select 00..11 is 500hz, 4khz, 32khz, 256khz
// (R25) interrupt taken at instruction boundary when flagged and enabled
`timescale 1ns/1ps
`default_nettype none
module mip_ctrl (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  // apb slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic                      pready_out,
  output logic                      pslverr_out,
  output logic [31:0]               prdata_out,
  // core side
  input  wire logic                 instr_boundary_in,
  input  wire logic                 enable_irq_instr_in,
  input  wire logic                 disable_irq_instr_in,
  input  wire logic                 return_irq_instr_in,
  output logic                      irq_take_out,
  output logic [mip_pkg::PC_W-1:0]  vector_addr_out,
  output logic                      global_irq_en_out,
  output logic                      core_restart_out,
  // timer and watchdog
  input  wire logic                 timer_overflow_in,
  input  wire logic                 watchdog_overflow_in,
  output logic                      watchdog_en_out,
  // pads
  input  wire logic [7:0]           port7_in,
  input  wire logic [1:0]           pattern_pin_in,
  // usb device controller
  input  wire logic                 usb_attached_in,
  input  wire logic                 usb_setup_ok_in,
  input  wire logic                 usb_cmd_unsupported_in,
  input  wire logic                 usb_suspend_in,
  input  wire logic                 usb_bus_reset_in,
  output logic                      usb_live_out,
  output logic                      usb_resume_drive_out,
  // clocks and power
  output logic                      sleep_out,
  output logic                      slow_clock_out,
  output logic [1:0]                dual_freq_sel_out,
  output logic                      pattern_enable_out
);
  mip_pkg::mip_state_t s;
  mip_pkg::mip_state_t next_s;

  // pattern event: edge past threshold or steady level at full count
  function automatic logic pat_event(input logic prev, input logic now,
                                     input logic [7:0] cnt,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
    logic ev;
    ev = 1'b0;
    if (prev != now) begin
      if (!now && cnt > hi) begin
        ev = 1'b1;
      end else if (now && cnt > lo) begin
        ev = 1'b1;
      end
    end else if (cnt == mip_pkg::PAT_FULL) begin
      ev = 1'b1;
    end
    return ev;
  endfunction

  // pattern counter: restart on edge or overflow
  function automatic logic [7:0] pat_count(input logic prev,
                                           input logic now,
                                           input logic [7:0] cnt);
    logic [7:0] c;
    c = cnt + 8'h01;
    if (prev != now || cnt == mip_pkg::PAT_FULL) begin
      c = 8'h00;
    end
    return c;
  endfunction

  logic [7:0] ev;
  logic       acc;
  logic       wr;
  logic       tick_now;
  logic       resume_ev;
  logic       wake;
  logic       pending;

  always_comb begin
    next_s = s;
    ev = 8'h00;
    acc = psel_in && penable_in && !s.pready;
    wr = acc && pwrite_in;
    tick_now = (s.tick == mip_pkg::PAT_TICK_CYCLES - 16'h0001);
    next_s.take = 1'b0;
    next_s.restart = 1'b0;
    next_s.pready = acc;
    next_s.pslverr = 1'b0;

    // pad synchronisers
    next_s.p7_s1 = port7_in;
    next_s.p7_s2 = s.p7_s1;
    next_s.p7_prev = s.p7_s2;
    next_s.pat_s1 = pattern_pin_in;
    next_s.pat_s2 = s.pat_s1;

    // event sources
    ev[mip_pkg::B_TIMER] = timer_overflow_in;            // (R2)
    ev[mip_pkg::B_PORT7] = (s.p7_s2 != s.p7_prev);       // (R3)
    // usb events only once the bus reset has been seen
    if (s.usb_live) begin                                // (R21)
      ev[mip_pkg::B_EP0] = usb_setup_ok_in
                           && usb_cmd_unsupported_in;    // (R6) (R22)
      ev[mip_pkg::B_SUSPEND] = usb_suspend_in
                               && !s.susp_prev;          // (R7)
    end
    ev[mip_pkg::B_USBRST] = usb_bus_reset_in;            // (R8)
    resume_ev = s.usb_live && s.susp_prev && !usb_suspend_in
                && !s.sfc[mip_pkg::SFC_DEV_RESUME];      // (R9)
    // resume interrupt only while running on the slow clock
    ev[mip_pkg::B_RESUME] = resume_ev
      && !s.sfc[mip_pkg::SFC_DUAL_N]
      && s.sfc[mip_pkg::SFC_RUN];                        // (R18)
    next_s.susp_prev = usb_suspend_in;

    // usb attach state survives watchdog reset
    if (!usb_attached_in) begin
      next_s.usb_live = 1'b0;
    end else if (usb_bus_reset_in) begin
      next_s.usb_live = 1'b1;                            // (R21)
    end

    // own resume drive ends once suspend drops
    if (s.susp_prev && !usb_suspend_in) begin
      next_s.sfc[mip_pkg::SFC_DEV_RESUME] = 1'b0;
    end

    // pattern detect
    if (s.opmode[mip_pkg::OPM_PAT_EN]) begin
      next_s.tick = tick_now ? 16'h0000 : s.tick + 16'h0001;
      if (tick_now) begin
        next_s.pat_prev = s.pat_s2;
        ev[mip_pkg::B_PAT_A] = pat_event(s.pat_prev[0], s.pat_s2[0],
                                         s.cnt_a, s.lo_a,
                                         s.hi_a);        // (R4)
        ev[mip_pkg::B_PAT_B] = pat_event(s.pat_prev[1], s.pat_s2[1],
                                         s.cnt_b, s.lo_b,
                                         s.hi_b);        // (R5)
        next_s.cnt_a = pat_count(s.pat_prev[0], s.pat_s2[0], s.cnt_a);
        next_s.cnt_b = pat_count(s.pat_prev[1], s.pat_s2[1], s.cnt_b);
      end
    end else begin
      next_s.tick = 16'h0000;
      next_s.cnt_a = 8'h00;
      next_s.cnt_b = 8'h00;
      next_s.pat_prev = s.pat_s2;
    end

    // apb register access
    if (acc) begin
      next_s.prdata = 32'h0000_0000;
      if (paddr_in == mip_pkg::OFF_STATUS) begin
        next_s.prdata[7:0] = s.status;
        // write one to clear; set below wins
        if (wr) begin
          next_s.status = s.status & ~pwdata_in[7:0];    // (R12)
        end
      end else if (paddr_in == mip_pkg::OFF_MASK) begin
        next_s.prdata[7:0] = s.mask;
        if (wr) begin
          next_s.mask = pwdata_in[7:0];                  // (R23)
        end
      end else if (paddr_in == mip_pkg::OFF_SFC) begin
        next_s.prdata[7:0] = s.sfc;
        if (wr) begin
          next_s.sfc = pwdata_in[7:0];                   // (R14) (R17)
        end
      end else if (paddr_in == mip_pkg::OFF_OPMODE) begin
        next_s.prdata[7:0] = s.opmode;
        if (wr) begin
          next_s.opmode = pwdata_in[7:0];                // (R24)
        end
      end else if (paddr_in == mip_pkg::OFF_LO_A) begin
        next_s.prdata[7:0] = s.lo_a;
        if (wr) begin
          next_s.lo_a = pwdata_in[7:0];
        end
      end else if (paddr_in == mip_pkg::OFF_HI_A) begin
        next_s.prdata[7:0] = s.hi_a;
        if (wr) begin
          next_s.hi_a = pwdata_in[7:0];
        end
      end else if (paddr_in == mip_pkg::OFF_LO_B) begin
        next_s.prdata[7:0] = s.lo_b;
        if (wr) begin
          next_s.lo_b = pwdata_in[7:0];
        end
      end else if (paddr_in == mip_pkg::OFF_HI_B) begin
        next_s.prdata[7:0] = s.hi_b;
        if (wr) begin
          next_s.hi_b = pwdata_in[7:0];
        end
      end else if (paddr_in == mip_pkg::OFF_PCNT) begin
        next_s.prdata[17:0] = {s.pat_s2, s.cnt_b, s.cnt_a};
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // flags set regardless of mask, set beats clear
    next_s.status = next_s.status | ev;                  // (R11)

    // wake from power-down
    wake = resume_ev
           || (!s.sfc[mip_pkg::SFC_WAKE_N]
               && ev[mip_pkg::B_PORT7]);                 // (R15)
    if (!s.sfc[mip_pkg::SFC_RUN] && wake) begin
      next_s.sfc[mip_pkg::SFC_RUN] = 1'b1;               // (R15)
    end

    // global enable from core instructions
    if (disable_irq_instr_in) begin
      next_s.gie = 1'b0;                                 // (R13)
    end else if (enable_irq_instr_in || return_irq_instr_in) begin
      next_s.gie = 1'b1;                                 // (R13)
    end

    // take at instruction boundary when flagged, unmasked, enabled
    pending = |(s.status & s.mask);                      // (R10)
    if (instr_boundary_in && s.gie && pending
        && s.sfc[mip_pkg::SFC_RUN]) begin
      next_s.take = 1'b1;                                // (R25) (R1)
      next_s.gie = 1'b0;
    end

    // watchdog restart keeps usb state
    if (watchdog_overflow_in && s.sfc[mip_pkg::SFC_WDT_EN]) begin
      next_s.restart = 1'b1;                             // (R19)
      next_s.take = 1'b0;
      next_s.gie = 1'b0;
      next_s.mask = mip_pkg::RST_MASK;
      next_s.sfc[mip_pkg::SFC_RUN] = 1'b1;               // (R15)
    end
  end

  // power-on: every field to its initial value
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;                                           // (R20)
      s.sfc <= mip_pkg::RST_SFC;
      s.opmode <= mip_pkg::RST_OPMODE;
      s.mask <= mip_pkg::RST_MASK;
      s.lo_a <= mip_pkg::RST_THR;
      s.hi_a <= mip_pkg::RST_THR;
      s.lo_b <= mip_pkg::RST_THR;
      s.hi_b <= mip_pkg::RST_THR;
    end else begin
      s <= next_s;
    end
  end

  assign pready_out = s.pready;
  assign pslverr_out = s.pslverr;
  assign prdata_out = s.prdata;
  assign irq_take_out = s.take;
  assign vector_addr_out = mip_pkg::IRQ_VECTOR;          // (R1)
  assign global_irq_en_out = s.gie;
  assign core_restart_out = s.restart;
  assign watchdog_en_out = s.sfc[mip_pkg::SFC_WDT_EN];
  assign usb_live_out = s.usb_live;
  assign usb_resume_drive_out = s.sfc[mip_pkg::SFC_DEV_RESUME];
  assign sleep_out = !s.sfc[mip_pkg::SFC_RUN];           // (R14)
  assign slow_clock_out = !s.sfc[mip_pkg::SFC_DUAL_N];   // (R17)
  assign dual_freq_sel_out = s.opmode[mip_pkg::OPM_FRQ_LO +: 2];
  assign pattern_enable_out = s.opmode[mip_pkg::OPM_PAT_EN];
endmodule
`default_nettype wire

// ==== verification/mip_ctrl_sva.sv ====
/*
 checker for the interrupt, power and reset control block.
 assumes it is bound to mip_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module mip_ctrl_sva (
  // clock, reset, apb
  input wire logic                     clock_in,
  input wire logic                     rst_in,
  input wire logic                     psel_in,
  input wire logic                     penable_in,
  input wire logic                     pready_out,
  input wire logic                     pslverr_out,
  // core side
  input wire logic                     instr_boundary_in,
  input wire logic                     enable_irq_instr_in,
  input wire logic                     disable_irq_instr_in,
  input wire logic                     irq_take_out,
  input wire logic [mip_pkg::PC_W-1:0] vector_addr_out,
  input wire logic                     global_irq_en_out,
  input wire logic                     core_restart_out,
  input wire logic                     sleep_out,
  // watchdog and usb
  input wire logic                     watchdog_overflow_in,
  input wire logic                     watchdog_en_out,
  input wire logic                     usb_bus_reset_in,
  input wire logic                     usb_live_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_req; psel_in && penable_in && !pready_out; endsequence
  sequence s_ans; pready_out ##1 !pready_out; endsequence
  sequence s_take; irq_take_out ##1 !irq_take_out; endsequence
  apb_answer_a: assert property (s_req |=> s_ans)
    else $error("apb answer missing");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  vector_fixed_a: assert property (vector_addr_out == 13'h0001)
    else $error("vector address wrong");
  take_cause_a: assert property (irq_take_out |-> $past(global_irq_en_out) && $past(instr_boundary_in)
    && !$past(sleep_out))
    else $error("take without cause");
  take_pulse_a: assert property ($rose(irq_take_out) |-> !global_irq_en_out ##0 s_take)
    else $error("take not a single pulse");
  disable_wins_a: assert property (disable_irq_instr_in |=> !global_irq_en_out)
    else $error("enable survives disable");
  enable_sets_a: assert property (enable_irq_instr_in && !disable_irq_instr_in && !watchdog_overflow_in
    && !global_irq_en_out |=> global_irq_en_out) else $error("enable ignored");
  restart_cause_a: assert property (core_restart_out |-> $past(watchdog_overflow_in) && $past(watchdog_en_out))
    else $error("restart without watchdog");
  restart_state_a: assert property (core_restart_out |-> !sleep_out && !global_irq_en_out)
    else $error("restart state wrong");
  live_cause_a: assert property ($rose(usb_live_out) |-> $past(usb_bus_reset_in))
    else $error("usb live without bus reset");
endmodule
bind mip_ctrl mip_ctrl_sva chk (.*);
`default_nettype wire

// ==== verification/mip_core_model.sv ====
/*
 core model: boundary every cycle, irq instructions on request.
 assumes irq_take_in is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module mip_core_model (
  // clock
  input  wire logic       clock_in,
  // core side
  input  wire logic       irq_take_in,
  output logic            boundary_out,
  output logic [2:0]      instr_out,
  output logic [7:0]      takes_out
);
  initial begin
    {boundary_out, instr_out, takes_out} = 12'h800;
  end
  // one-hot: enable, disable, return
  task automatic instr(input logic [2:0] k);
    @(posedge clock_in);
    instr_out <= k;
    @(posedge clock_in);
    instr_out <= 3'h0;
  endtask
  always @(posedge clock_in) begin
    if (irq_take_in === 1'b1) takes_out <= takes_out + 8'h01;
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
/*
 self-checking bench for mip_ctrl with a core model.
 assumes the package compiled first and the checker bound.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in, port7_in, takes;
  logic [31:0] pwdata_in, prdata_out;
  logic        instr_boundary_in, irq_take_out, global_irq_en_out, core_restart_out, watchdog_en_out;
  logic        usb_attached_in, usb_suspend_in, usb_live_out, usb_resume_drive_out;
  logic        sleep_out, slow_clock_out, pattern_enable_out;
  logic [1:0]  pattern_pin_in, dual_freq_sel_out;
  logic [2:0]  ins;
  logic [4:0]  ev;
  logic [12:0] vector_addr_out;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          miscompares, checks_done, restarts;
  mip_ctrl dut (.*, .enable_irq_instr_in(ins[2]), .disable_irq_instr_in(ins[1]), .return_irq_instr_in(ins[0]),
    .timer_overflow_in(ev[0]), .watchdog_overflow_in(ev[1]), .usb_setup_ok_in(ev[2]),
    .usb_cmd_unsupported_in(ev[3]), .usb_bus_reset_in(ev[4]));
  mip_core_model core (.clock_in(clock_in), .irq_take_in(irq_take_out), .boundary_out(instr_boundary_in),
    .instr_out(ins), .takes_out(takes));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] x, input string m);
    checks_done++;
    if (got !== x) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, x);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] x);
    exp_q.push_back({w, x});
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'b1);
    {psel_in, penable_in} <= 2'b00;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, {24'h0, d}, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(a, 1'b0, 32'h0, {1'b0, x});
  endtask
  task automatic evp(input logic [4:0] k);
    ev <= k;
    @(posedge clock_in);
    ev <= 5'h0;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_in) begin
    if (core_restart_out === 1'b1) restarts++;
    if (psel_in && penable_in && pready_out === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({pslverr_out, e[33] ? 32'h0 : prdata_out}, e[32:0], "apb answer");
    end else if (psel_in && penable_in && pready_out === 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: apb answer with no request noted", $time);
    end
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    {rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {4'h8, 8'h00, 32'h0};
    {port7_in, pattern_pin_in, ev, usb_suspend_in, usb_attached_in} = 17'h1;
    void'($urandom(32'he6c6));
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd(mip_pkg::OFF_SFC, 32'hd7);
    rd(mip_pkg::OFF_OPMODE, 32'he0);
    rd(mip_pkg::OFF_MASK, 32'h0);
    chk({31'h0, sleep_out, slow_clock_out}, 33'h0, "clocks at reset");
    for (int k = 0; k < 4; k++) begin
      wr(mip_pkg::OFF_OPMODE, {k[1:0], 6'h00});
      chk({31'h0, dual_freq_sel_out}, 33'(k), "frequency select");
    end
    $display("end reset");
    core.instr(3'b100);
    evp(5'h01);
    rd(mip_pkg::OFF_STATUS, 32'h01);
    chk({25'h0, takes}, 33'h0, "masked take");
    wr(mip_pkg::OFF_MASK, 8'h01);
    rd(mip_pkg::OFF_MASK, 32'h01);
    chk({25'h0, takes}, 33'h1, "take count");
    chk({20'h0, vector_addr_out}, 33'h1, "vector");
    wr(mip_pkg::OFF_STATUS, 8'hff);
    core.instr(3'b010);
    evp(5'h01);
    rd(mip_pkg::OFF_STATUS, 32'h01);
    chk({25'h0, takes}, 33'h1, "take while disabled");
    wr(mip_pkg::OFF_STATUS, 8'hff);
    core.instr(3'b001);
    @(posedge clock_in);
    chk({32'h0, global_irq_en_out}, 33'h1, "return enables");
    core.instr(3'b010);
    $display("end interrupts");
    port7_in <= port7_in ^ 8'(1 << ($urandom % 8));
    repeat (4) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h10);
    wr(mip_pkg::OFF_STATUS, 8'hff);
    evp(5'h0c);
    rd(mip_pkg::OFF_STATUS, 32'h0);
    evp(5'h10);
    chk({32'h0, usb_live_out}, 33'h1, "usb live");
    evp(5'h0c);
    rd(mip_pkg::OFF_STATUS, 32'h0a);
    wr(mip_pkg::OFF_STATUS, 8'hff);
    evp(5'h04);
    usb_suspend_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h04);
    wr(mip_pkg::OFF_STATUS, 8'hff);
    usb_suspend_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h0);
    wr(mip_pkg::OFF_SFC, 8'h57);
    chk({32'h0, slow_clock_out}, 33'h1, "slow clock");
    usb_suspend_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    usb_suspend_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h84);
    wr(mip_pkg::OFF_STATUS, 8'hff);
    wr(mip_pkg::OFF_SFC, 8'h5f);
    chk({32'h0, usb_resume_drive_out}, 33'h1, "resume drive");
    usb_suspend_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    usb_suspend_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h04);
    chk({32'h0, usb_resume_drive_out}, 33'h0, "resume drive end");
    wr(mip_pkg::OFF_SFC, 8'hd7);
    $display("end usb");
    wr(mip_pkg::OFF_OPMODE, 8'he4);
    chk({32'h0, pattern_enable_out}, 33'h1, "pattern enable");
    wr(mip_pkg::OFF_HI_A, 8'h01);
    wr(mip_pkg::OFF_HI_B, 8'hc8);
    pattern_pin_in <= 2'b11;
    repeat (20) @(posedge clock_in);
    wr(mip_pkg::OFF_STATUS, 8'hff);
    repeat (100) @(posedge clock_in);
    pattern_pin_in <= 2'b00;
    repeat (20) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h20);
    wr(mip_pkg::OFF_STATUS, 8'hff);
    repeat (4200) @(posedge clock_in);
    rd(mip_pkg::OFF_STATUS, 32'h60);
    wr(mip_pkg::OFF_LO_A, 8'h5a);
    rd(mip_pkg::OFF_LO_A, 32'h5a);
    $display("end pattern");
    repeat (4) @(posedge clock_in);
    wr(mip_pkg::OFF_SFC, 8'h87);
    chk({32'h0, sleep_out}, 33'h1, "sleep");
    port7_in <= port7_in ^ 8'(1 << ($urandom % 8));
    repeat (5) @(posedge clock_in);
    chk({32'h0, sleep_out}, 33'h0, "port wake");
    wr(mip_pkg::OFF_SFC, 8'hf7);
    chk({32'h0, watchdog_en_out}, 33'h1, "watchdog enable");
    wr(mip_pkg::OFF_MASK, 8'h81);
    evp(5'h02);
    chk(33'(restarts), 33'h1, "restart");
    chk({32'h0, usb_live_out}, 33'h1, "usb kept");
    rd(mip_pkg::OFF_MASK, 32'h0);
    bus(8'h40, 1'b0, 32'h0, {1'b1, 32'h0});
    bus(8'h40, 1'b1, 32'h5a, {1'b1, 32'h0});
    chk(33'(exp_q.size()), 33'h0, "answers missing");
    $display("end power");
    close_out();
  end
endmodule
`default_nettype wire
